/* bbpm_top.sv */
// Our own choice: the plain strobed port.
`timescale 1ns/1ps
`include "bbpm_regs.svh"
module bbpm_top (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output bbpm_pkg::bbpm_byte_t rdata_o,
  // primary io address decode, one-cycle registered result
  input wire logic io_valid_i,
  input wire logic [15:0] io_addr_i,
  input wire logic io_window_hit_i,
  output logic claim_o,
  output logic forward_o,
  // burst policy
  output logic up_multi_line_o,
  output logic dn_burst_en_o,
  // write flow: src_valid_i offers a word, tgt_ack_i says target took one
  input wire logic pri_side_i,
  input wire logic src_valid_i,
  input wire logic src_last_i,
  input wire logic tgt_ack_i,
  input wire logic buf_empty_i,
  output logic src_accept_o,
  output logic src_hold_o,
  output logic drain_req_o
);
  import bbpm_pkg::*;

  typedef struct packed {
    bbpm_byte_t buf_ctl;
    bbpm_byte_t port_map;
    bbpm_byte_t port_en;
    bbpm_byte_t chip_ctl;
    bbpm_byte_t rdata;
    logic claim;
    logic forward;
    logic up_multi;
    logic dn_burst;
    bbpm_flow_e flow;
    logic last_pend;
    logic accept;
    logic hold;
    logic drain;
  } bbpm_state_s;

  bbpm_state_s st_reg;
  bbpm_state_s st_next;
  logic [6:0] hit;
  logic posted;

  bbpm_legacy_decode u_dec (
    .io_addr_i(io_addr_i),
    .hit_o(hit)
  );

  assign posted = pri_side_i ? st_reg.buf_ctl[`BBPM_BIT_PRI_POST]
                             : st_reg.buf_ctl[`BBPM_BIT_SEC_POST];

  always_comb begin
    st_next = st_reg;
    st_next.rdata = 8'h00;
    // reserved positions masked on write so they never steer anything
    if (wr_i) begin
      unique case (addr_i)
        `BBPM_OFF_BUFFER_CONTROL: st_next.buf_ctl = wdata_i & `BBPM_MASK_BUFFER_CONTROL;
        `BBPM_OFF_LEGACY_PORT_MAP: st_next.port_map = wdata_i & `BBPM_MASK_PORT;
        `BBPM_OFF_PORT_ENABLE: st_next.port_en = wdata_i & `BBPM_MASK_PORT;
        `BBPM_OFF_CHIP_CONTROL: st_next.chip_ctl = wdata_i & `BBPM_MASK_CHIP_CONTROL;
        default: ;
      endcase
    end
    // unmapped addresses read zero
    if (rd_i) begin
      unique case (addr_i)
        `BBPM_OFF_BUFFER_CONTROL: st_next.rdata = st_reg.buf_ctl;
        `BBPM_OFF_LEGACY_PORT_MAP: st_next.rdata = st_reg.port_map;
        `BBPM_OFF_PORT_ENABLE: st_next.rdata = st_reg.port_en;
        `BBPM_OFF_CHIP_CONTROL: st_next.rdata = st_reg.chip_ctl;
        default: st_next.rdata = 8'h00;
      endcase
    end
    st_next.up_multi = st_reg.buf_ctl[`BBPM_BIT_UP_MULTI] &
                       ~st_reg.chip_ctl[`BBPM_BIT_CHIP_UP_INHIBIT];
    st_next.dn_burst = st_reg.buf_ctl[`BBPM_BIT_DN_BURST];
    // a legacy hit with map bit clear vetoes the io window claim
    st_next.claim = 1'b0;
    st_next.forward = 1'b0;
    if (io_valid_i) begin
      if (|(hit & st_reg.port_en[6:0])) begin
        st_next.forward = |(hit & st_reg.port_en[6:0] & st_reg.port_map[6:0]);
        st_next.claim = st_next.forward;
      end else if (|hit) begin
        st_next.claim = io_window_hit_i & |(hit & st_reg.port_map[6:0]);
        st_next.forward = st_next.claim;
      end else begin
        st_next.claim = io_window_hit_i;
        st_next.forward = io_window_hit_i;
      end
    end
    // write flow; posted path takes every offered word at once
    st_next.accept = 1'b0;
    st_next.drain = 1'b0;
    unique case (st_reg.flow)
      BBPM_IDLE: begin
        st_next.hold = 1'b0;
        if (src_valid_i) begin
          if (posted) begin
            st_next.accept = 1'b1;
          end else if (!buf_empty_i) begin
            st_next.flow = BBPM_DRAIN;
            st_next.drain = 1'b1;
            st_next.hold = 1'b1;
          end else begin
            st_next.accept = 1'b1;
            st_next.last_pend = src_last_i;
            st_next.hold = 1'b1;
            st_next.flow = BBPM_WAIT_TGT;
          end
        end
      end
      BBPM_DRAIN: begin
        st_next.drain = ~buf_empty_i;
        // master is let go once drained; it must offer its word again
        if (buf_empty_i) begin
          st_next.hold = 1'b0;
          st_next.flow = BBPM_IDLE;
        end
      end
      BBPM_WAIT_TGT: begin
        // master stays held until the target takes the final word, or takes a word while no further word is offered
        if (tgt_ack_i) begin
          if (st_reg.last_pend) begin
            st_next.hold = 1'b0;
            st_next.flow = BBPM_IDLE;
          end else if (src_valid_i) begin
            st_next.accept = 1'b1;
            st_next.last_pend = src_last_i;
          end else begin
            st_next.flow = BBPM_IDLE;
            st_next.hold = 1'b0;
          end
        end
      end
      default: st_next.flow = BBPM_IDLE;
    endcase
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      st_reg <= '{buf_ctl: `BBPM_RST_BUFFER_CONTROL,
                  port_map: `BBPM_RST_LEGACY_PORT_MAP,
                  port_en: `BBPM_RST_PORT_ENABLE,
                  chip_ctl: `BBPM_RST_CHIP_CONTROL,
                  rdata: 8'h00,
                  claim: 1'b0,
                  forward: 1'b0,
                  up_multi: 1'b0,
                  dn_burst: 1'b1,
                  flow: BBPM_IDLE,
                  last_pend: 1'b0,
                  accept: 1'b0,
                  hold: 1'b0,
                  drain: 1'b0};
    end else begin
      st_reg <= st_next;
    end
  end

  assign rdata_o = st_reg.rdata;
  assign claim_o = st_reg.claim;
  assign forward_o = st_reg.forward;
  assign up_multi_line_o = st_reg.up_multi;
  assign dn_burst_en_o = st_reg.dn_burst;
  assign src_accept_o = st_reg.accept;
  assign src_hold_o = st_reg.hold;
  assign drain_req_o = st_reg.drain;
endmodule

/* bbpm_regs.svh */
`ifndef BBPM_REGS_SVH
`define BBPM_REGS_SVH
`define BBPM_ADDR_W 8
`define BBPM_OFF_PORT_ENABLE 8'h58
`define BBPM_OFF_BUFFER_CONTROL 8'h59
`define BBPM_OFF_LEGACY_PORT_MAP 8'h5a
`define BBPM_OFF_CHIP_CONTROL 8'h40
`define BBPM_RST_BUFFER_CONTROL 8'h07
`define BBPM_RST_LEGACY_PORT_MAP 8'h00
`define BBPM_RST_PORT_ENABLE 8'h00
`define BBPM_RST_CHIP_CONTROL 8'h00
`define BBPM_MASK_BUFFER_CONTROL 8'h17
`define BBPM_MASK_PORT 8'h7f
`define BBPM_MASK_CHIP_CONTROL 8'h10
`define BBPM_BIT_SEC_POST 0
`define BBPM_BIT_PRI_POST 1
`define BBPM_BIT_DN_BURST 2
`define BBPM_BIT_UP_MULTI 4
`define BBPM_BIT_CHIP_UP_INHIBIT 4
`define BBPM_IO_W 16
`endif

/* bbpm_pkg.sv */
package bbpm_pkg;
  typedef enum logic [1:0] {
    BBPM_IDLE = 2'b00,
    BBPM_DRAIN = 2'b01,
    BBPM_WAIT_TGT = 2'b10
  } bbpm_flow_e;
  typedef logic [7:0] bbpm_byte_t;
  typedef logic [15:0] bbpm_io_t;
endpackage

/* bbpm_legacy_decode.sv */
`timescale 1ns/1ps
`include "bbpm_regs.svh"
module bbpm_legacy_decode (
  input wire logic [15:0] io_addr_i,
  output logic [6:0] hit_o
);
  // inclusive on both ends; 10-bit alias ignored on purpose: full compare only
  function automatic logic in_range(input logic [15:0] a, input logic [15:0] lo,
                                    input logic [15:0] hi);
    in_range = (a >= lo) && (a <= hi);
  endfunction
  always_comb begin
    hit_o[0] = in_range(io_addr_i, 16'h03f8, 16'h03ff);
    hit_o[1] = in_range(io_addr_i, 16'h02f8, 16'h02ff);
    hit_o[2] = in_range(io_addr_i, 16'h03e8, 16'h03ef);
    hit_o[3] = in_range(io_addr_i, 16'h02e8, 16'h02ef);
    hit_o[4] = in_range(io_addr_i, 16'h03bc, 16'h03bf) ||
               in_range(io_addr_i, 16'h07bc, 16'h07bf);
    hit_o[5] = in_range(io_addr_i, 16'h0378, 16'h037f) ||
               in_range(io_addr_i, 16'h0778, 16'h077b);
    hit_o[6] = in_range(io_addr_i, 16'h0278, 16'h027f) ||
               in_range(io_addr_i, 16'h0678, 16'h067b);
  end
endmodule

/* bbpm_top_chk.sv */
`timescale 1ns/1ps
module bbpm_chk (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire bbpm_pkg::bbpm_byte_t rdata_o,
  input wire logic io_valid_i,
  input wire logic [15:0] io_addr_i,
  input wire logic io_window_hit_i,
  input wire logic claim_o,
  input wire logic forward_o,
  input wire logic dn_burst_en_o,
  input wire logic src_valid_i,
  input wire logic tgt_ack_i,
  input wire logic src_accept_o,
  input wire logic src_hold_o,
  input wire logic drain_req_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  sequence s_rd(a);
    rd_i && addr_i == a;
  endsequence
  sequence s_wr_buf;
    wr_i && addr_i == 8'h59;
  endsequence
  property p_buf_rsv;
    s_rd(8'h59) |=> (rdata_o & 8'he8) == 8'h00;
  endproperty
  a_buf_rsv: assert property (p_buf_rsv) else $error("buffer reserved bits set");
  property p_map_rsv;
    s_rd(8'h5a) |=> !rdata_o[7];
  endproperty
  a_map_rsv: assert property (p_map_rsv) else $error("map bit 7 set");
  property p_unmapped;
    s_rd(8'h5b) |=> rdata_o == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  // output follows the register one cycle after it changes, so two after the strobe
  property p_dn;
    s_wr_buf |-> ##2 dn_burst_en_o == |($past(wdata_i, 2) & 8'h04);
  endproperty
  a_dn: assert property (p_dn) else $error("downstream burst enable wrong");
  property p_gap;
    !io_valid_i |=> !claim_o && !forward_o;
  endproperty
  a_gap: assert property (p_gap) else $error("claim without io cycle");
  property p_nohit;
    io_valid_i && io_addr_i[15:11] != 5'h00 |=> claim_o == $past(io_window_hit_i);
  endproperty
  a_nohit: assert property (p_nohit) else $error("claim not window outside ranges");
  property p_wait;
    src_hold_o && !tgt_ack_i |=> !src_accept_o;
  endproperty
  a_wait: assert property (p_wait) else $error("word taken before target ack");
  property p_drain;
    drain_req_o |-> !src_accept_o;
  endproperty
  a_drain: assert property (p_drain) else $error("word taken while draining");
  property p_src;
    src_accept_o |-> $past(src_valid_i);
  endproperty
  a_src: assert property (p_src) else $error("accept without offer");
endmodule
bind bbpm_top bbpm_chk u_chk (.mclk_i, .rst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
  .io_valid_i, .io_addr_i, .io_window_hit_i, .claim_o, .forward_o, .dn_burst_en_o, .src_valid_i,
  .tgt_ack_i, .src_accept_o, .src_hold_o, .drain_req_o);

/* bbpm_top_tb_top.sv */
`timescale 1ns/1ps
module bbpm_top_tb_top;
  import bbpm_pkg::*;
  logic mclk_i = 1'h0, rst_i = 1'h1, wr_i = 1'h0, rd_i = 1'h0, io_valid_i = 1'h0;
  logic io_window_hit_i = 1'h0, pri_side_i = 1'h1, src_valid_i = 1'h0, src_last_i = 1'h0;
  logic tgt_ack_i = 1'h0, buf_empty_i = 1'h1;
  logic [7:0] addr_i = 8'h00, wdata_i = 8'h00;
  logic [15:0] io_addr_i = 16'h0000;
  bbpm_byte_t rdata_o;
  logic claim_o, forward_o, up_multi_line_o, dn_burst_en_o, src_accept_o, src_hold_o, drain_req_o;
  int error_cnt = 0;
  int comparisons = 0;
  // address then expected claim, map 55h, window on: both ends plus neighbours
  logic [19:0] rows [27] = '{20'h03f81, 20'h03ff1, 20'h02f80, 20'h02ff0, 20'h03e81, 20'h03ef1,
    20'h02e80, 20'h02ef0, 20'h03bc1, 20'h03bf1, 20'h07bc1, 20'h07bf1, 20'h03780, 20'h037f0,
    20'h07780, 20'h077b0, 20'h02781, 20'h027f1, 20'h06781, 20'h067b1, 20'h02f71, 20'h02f01,
    20'h03771, 20'h077c1, 20'h02e71, 20'h03801, 20'h08001};
  bbpm_top dut (.mclk_i, .rst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .io_valid_i,
    .io_addr_i, .io_window_hit_i, .claim_o, .forward_o, .up_multi_line_o, .dn_burst_en_o,
    .pri_side_i, .src_valid_i, .src_last_i, .tgt_ack_i, .buf_empty_i, .src_accept_o,
    .src_hold_o, .drain_req_o);
  initial begin
    forever #10 mclk_i = ~mclk_i;
  end
  task automatic chk(string n, logic [15:0] s, logic [15:0] e);
    comparisons++;
    if (s !== e) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic final_report();
    $display("checks %0d errors %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(posedge mclk_i);
    wr_i <= 1'h1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge mclk_i);
    wr_i <= 1'h0;
  endtask
  task automatic rd(logic [7:0] a, logic [7:0] e);
    @(posedge mclk_i);
    rd_i <= 1'h1;
    addr_i <= a;
    @(posedge mclk_i);
    rd_i <= 1'h0;
    #1 chk("rdata", rdata_o, e);
  endtask
  task automatic io(logic [15:0] a, logic w);
    @(posedge mclk_i);
    io_valid_i <= 1'h1;
    io_addr_i <= a;
    io_window_hit_i <= w;
    @(posedge mclk_i);
    io_valid_i <= 1'h0;
    #1;
  endtask
  initial begin
    repeat (6) @(posedge mclk_i);
    rst_i <= 1'h0;
    #1 chk("bursts", {dn_burst_en_o, up_multi_line_o}, 2'h2);
    rd(8'h59, 8'h07);
    @(posedge mclk_i);
    #1 chk("rdata_gone", rdata_o, 8'h00);
    rd(8'h5a, 8'h00);
    wr(8'h59, 8'hff);
    rd(8'h59, 8'h17);
    chk("up", up_multi_line_o, 1'h1);
    wr(8'h40, 8'h10);
    rd(8'h5b, 8'h00);
    chk("up", up_multi_line_o, 1'h0);
    wr(8'h59, 8'h13);
    wr(8'h5a, 8'hff);
    rd(8'h5a, 8'h7f);
    chk("dn", dn_burst_en_o, 1'h0);
    wr(8'h5a, 8'h55);
    foreach (rows[i]) begin
      io(rows[i][19:4], 1'h1);
      chk("claim", claim_o, rows[i][0]);
    end
    wr(8'h58, 8'h7f);
    io(16'h03f8, 1'h0);
    chk("fwd", {claim_o, forward_o}, 2'h3);
    io(16'h02f8, 1'h1);
    chk("fwd", {claim_o, forward_o}, 2'h0);
    @(posedge mclk_i);
    src_valid_i <= 1'h1;
    @(posedge mclk_i);
    src_valid_i <= 1'h0;
    #1 chk("acc", src_accept_o, 1'h1);
    wr(8'h59, 8'h10);
    buf_empty_i <= 1'h0;
    @(posedge mclk_i);
    src_valid_i <= 1'h1;
    @(posedge mclk_i);
    src_valid_i <= 1'h0;
    buf_empty_i <= 1'h1;
    #1 chk("drain", {drain_req_o, src_hold_o, src_accept_o}, 3'h6);
    for (int k = 0; k < 20 && drain_req_o !== 1'h0; k++) begin
      @(posedge mclk_i);
      #1;
    end
    if (drain_req_o !== 1'h0) begin
      error_cnt++;
      final_report();
    end
    @(posedge mclk_i);
    pri_side_i <= 1'h0;
    src_valid_i <= 1'h1;
    @(posedge mclk_i);
    src_last_i <= 1'h1;
    #1 chk("acc1", {src_accept_o, src_hold_o}, 2'h3);
    @(posedge mclk_i);
    tgt_ack_i <= 1'h1;
    #1 chk("acc2", src_accept_o, 1'h0);
    @(posedge mclk_i);
    tgt_ack_i <= 1'h0;
    src_valid_i <= 1'h0;
    #1 chk("acc3", {src_accept_o, src_hold_o}, 2'h3);
    @(posedge mclk_i);
    tgt_ack_i <= 1'h1;
    #1 chk("hold", src_hold_o, 1'h1);
    @(posedge mclk_i);
    tgt_ack_i <= 1'h0;
    #1 chk("hold", src_hold_o, 1'h0);
    // mid-run reset must bring every register back to its reset value
    @(posedge mclk_i);
    rst_i <= 1'h1;
    repeat (2) @(posedge mclk_i);
    rst_i <= 1'h0;
    #1 chk("rst_out", {dn_burst_en_o, up_multi_line_o, src_hold_o}, 3'h4);
    rd(8'h59, 8'h07);
    rd(8'h5a, 8'h00);
    rd(8'h58, 8'h00);
    rd(8'h40, 8'h00);
    final_report();
  end
endmodule
